// ---- dffsc_dual.sv ----
// module: two independent edge-triggered storage cells with async set and clear
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// (RQ1) Two identical cells run side by side, each with its own clock, data, set, clear and outputs.
// (RQ2) A low set with clear high drives the true output high and the complement low at once.
// (RQ3) A low clear drives the true output low and the complement high at once.
// (RQ4) With set and clear both low, clear wins.
// (RQ5) A cell clock edge has effect only while set and clear are both high.
// (RQ6) A rising cell clock edge with both controls high loads data into the true output.
// (RQ7) Between cell clock rising edges the stored value holds whatever data does.
// (RQ8) The complement output is always the inverse of the true output.
module dffsc_dual
    import dffsc_pkg::*;
(
    // system
    input  wire logic            CLK,
    input  wire logic            RESETN,
    // cell pins
    input  wire dffsc_cell_in_t  CELL_IN  [DFFSC_NUM_CELLS],
    output var  dffsc_cell_out_t CELL_OUT [DFFSC_NUM_CELLS]
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // output level a cell shows for a given control pair and stored bit
    function automatic logic dffsc_level(input logic set_n, input logic clr_n,
                                         input logic stored);
        logic lvl;
        lvl = stored;
        if (!clr_n) begin
            lvl = DFFSC_FORCE_CLR;
        end else if (!set_n) begin
            lvl = DFFSC_FORCE_SET;
        end
        return lvl;
    endfunction : dffsc_level

    // ----------------------------------------------------------------
    // cells
    // ----------------------------------------------------------------
    for (genvar c = 0; c < DFFSC_NUM_CELLS; c++) begin : g_cell  // [RQ1]
        logic store_r;
        logic clk_prev_r;
        logic clk_rise;
        logic ctl_idle;
        logic q_lvl;

        // ------------------------------------------------------------
        // cell clock edge and control decode
        // ------------------------------------------------------------
        // the cell clock is a sampled level, so a rise shows one sample late
        // and two rises need a low sample between them
        assign clk_rise = CELL_IN[c].cell_clk & ~clk_prev_r;
        assign ctl_idle = CELL_IN[c].async_set_n & CELL_IN[c].async_clear_n;

        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
                clk_prev_r <= DFFSC_CLKPREV_RST;
            end else begin
                clk_prev_r <= CELL_IN[c].cell_clk;
            end
        end

        // ------------------------------------------------------------
        // storage
        // ------------------------------------------------------------
        // forced levels are stored too, so the cell keeps them after release;
        // a control pulse that misses every clock edge shows only while it lasts
        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
                store_r <= DFFSC_STORE_RST;
            end else if (!ctl_idle) begin  // [RQ5]
                store_r <= dffsc_level(CELL_IN[c].async_set_n,
                                       CELL_IN[c].async_clear_n, store_r);
            end else if (clk_rise) begin
                store_r <= CELL_IN[c].data;  // [RQ6]
            end
        end  // [RQ7]

        // ------------------------------------------------------------
        // outputs
        // ------------------------------------------------------------
        // forcing bypasses the flop so it shows without waiting for a clock;
        // the store uses the same function, so shown and kept levels agree
        assign q_lvl = dffsc_level(CELL_IN[c].async_set_n,
                                   CELL_IN[c].async_clear_n, store_r);  // [RQ2] [RQ3] [RQ4]

        always_comb begin
            CELL_OUT[c].q   = q_lvl;
            CELL_OUT[c].q_n = ~q_lvl;  // [RQ8]
        end

        // ------------------------------------------------------------
        // checks: forcing
        // ------------------------------------------------------------
        a_set_forces_high: assert property ( // [RQ2]
            @(posedge CLK) disable iff (!RESETN)
            (!CELL_IN[c].async_set_n && CELL_IN[c].async_clear_n)
                |-> (CELL_OUT[c].q && !CELL_OUT[c].q_n))
            else $error("set did not force output high");

        a_clear_forces_low: assert property ( // [RQ3]
            @(posedge CLK) disable iff (!RESETN)
            !CELL_IN[c].async_clear_n |-> (!CELL_OUT[c].q && CELL_OUT[c].q_n))
            else $error("clear did not force output low");

        a_clear_beats_set: assert property ( // [RQ4]
            @(posedge CLK) disable iff (!RESETN)
            (!CELL_IN[c].async_clear_n && !CELL_IN[c].async_set_n)
                ##1 (CELL_IN[c].async_clear_n && CELL_IN[c].async_set_n && !clk_rise)
                |-> !CELL_OUT[c].q)
            else $error("clear did not win over set");

        a_both_low_forces: assert property ( // [RQ4]
            @(posedge CLK) disable iff (!RESETN)
            (!CELL_IN[c].async_clear_n && !CELL_IN[c].async_set_n)
                |-> (!CELL_OUT[c].q && CELL_OUT[c].q_n))
            else $error("both controls low did not give a low output");

        // a forced level must outlive its control by way of the stored bit
        a_set_kept_after: assert property ( // [RQ2]
            @(posedge CLK) disable iff (!RESETN)
            (!CELL_IN[c].async_set_n && CELL_IN[c].async_clear_n)
                ##1 (ctl_idle && !clk_rise) |-> CELL_OUT[c].q)
            else $error("set level was lost on release");

        a_clear_kept_after: assert property ( // [RQ3]
            @(posedge CLK) disable iff (!RESETN)
            !CELL_IN[c].async_clear_n ##1 (ctl_idle && !clk_rise) |-> !CELL_OUT[c].q)
            else $error("clear level was lost on release");

        // ------------------------------------------------------------
        // checks: capture and hold
        // ------------------------------------------------------------
        a_forced_ignores_edge: assert property ( // [RQ5]
            @(posedge CLK) disable iff (!RESETN)
            (!CELL_IN[c].async_clear_n && clk_rise)
                ##1 (ctl_idle && !clk_rise) |-> !CELL_OUT[c].q)
            else $error("edge took effect while forced");

        a_edge_captures: assert property ( // [RQ6]
            @(posedge CLK) disable iff (!RESETN)
            (ctl_idle && clk_rise)
                ##1 (ctl_idle && !clk_rise)[*2]
                |-> CELL_OUT[c].q == $past(CELL_IN[c].data, 2))
            else $error("edge did not load data");

        a_hold_between: assert property ( // [RQ7]
            @(posedge CLK) disable iff (!RESETN)
            (ctl_idle && !clk_rise) ##1 (ctl_idle && !clk_rise)
                |-> $stable(CELL_OUT[c].q))
            else $error("output changed without a clock edge");

        a_data_ignored: assert property ( // [RQ7]
            @(posedge CLK) disable iff (!RESETN)
            (ctl_idle && !clk_rise)
                ##1 (ctl_idle && !clk_rise && $changed(CELL_IN[c].data))
                |-> $stable(CELL_OUT[c].q_n))
            else $error("data moved the output between edges");

        a_idle_shows_store: assert property ( // [RQ7]
            @(posedge CLK) disable iff (!RESETN)
            ctl_idle |-> CELL_OUT[c].q == store_r)
            else $error("idle output is not the stored bit");

        // the answer stands one cycle after the edge that was taken
        a_edge_loads_next: assert property ( // [RQ6]
            @(posedge CLK) disable iff (!RESETN)
            (ctl_idle && clk_rise) ##1 ctl_idle
                |-> (CELL_OUT[c].q == $past(CELL_IN[c].data)
                     && CELL_OUT[c].q_n == !$past(CELL_IN[c].data)))
            else $error("edge did not load data and its inverse");

        a_forced_no_load: assert property ( // [RQ5]
            @(posedge CLK) disable iff (!RESETN)
            (!ctl_idle && clk_rise) ##1 ctl_idle
                |-> CELL_OUT[c].q == $past(CELL_OUT[c].q))
            else $error("edge under a forcing control loaded data");

        a_pair_inverse: assert property ( // [RQ8]
            @(posedge CLK) disable iff (!RESETN)
            CELL_OUT[c].q_n == !CELL_OUT[c].q)
            else $error("complement is not inverse of true output");

        c_capture_one: cover property (
            @(posedge CLK) disable iff (!RESETN)
            ctl_idle && clk_rise && CELL_IN[c].data ##1 CELL_OUT[c].q);
        c_both_low: cover property (
            @(posedge CLK) disable iff (!RESETN)
            !CELL_IN[c].async_clear_n && !CELL_IN[c].async_set_n);
        c_clear_wins: cover property (
            @(posedge CLK) disable iff (!RESETN)
            (!CELL_IN[c].async_clear_n && !CELL_IN[c].async_set_n) ##1 ctl_idle);
        c_edge_forced: cover property (
            @(posedge CLK) disable iff (!RESETN)
            (!ctl_idle && clk_rise) ##1 ctl_idle);
    end

    // ----------------------------------------------------------------
    // checks: cells side by side
    // ----------------------------------------------------------------
    // each cell keeps its own edge detector, so an edge on one never moves the other
    a_cells_apart: assert property ( // [RQ1]
        @(posedge CLK) disable iff (!RESETN)
        (g_cell[1].ctl_idle && !g_cell[1].clk_rise && g_cell[0].clk_rise)
            ##1 g_cell[1].ctl_idle |-> $stable(CELL_OUT[1].q))
        else $error("cell 1 moved on a cell 0 edge");

    a_cells_apart_back: assert property ( // [RQ1]
        @(posedge CLK) disable iff (!RESETN)
        (g_cell[0].ctl_idle && !g_cell[0].clk_rise && g_cell[1].clk_rise)
            ##1 g_cell[0].ctl_idle |-> $stable(CELL_OUT[0].q))
        else $error("cell 0 moved on a cell 1 edge");

    c_set_then_capture: cover property (
        @(posedge CLK) disable iff (!RESETN)
        !CELL_IN[0].async_set_n ##1 g_cell[0].ctl_idle ##[1:4] g_cell[0].clk_rise);

endmodule : dffsc_dual

`default_nettype wire

// ---- dffsc_pkg.sv ----
// package: types and constants for the dual set/clear storage cell block
`default_nettype none
package dffsc_pkg;

    // ----------------------------------------------------------------
    // sizes and reset values
    // ----------------------------------------------------------------
    localparam int   DFFSC_NUM_CELLS  = 2;
    localparam logic DFFSC_STORE_RST  = 1'h0;
    // a high reset value keeps a cell clock held high through reset from
    // looking like a rising edge at release
    localparam logic DFFSC_CLKPREV_RST = 1'h1;
    localparam logic DFFSC_FORCE_SET  = 1'h1;
    localparam logic DFFSC_FORCE_CLR  = 1'h0;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cell_clk;
        logic data;
        logic async_set_n;
        logic async_clear_n;
    } dffsc_cell_in_t;

    typedef struct packed {
        logic q;
        logic q_n;
    } dffsc_cell_out_t;

endpackage : dffsc_pkg

`default_nettype wire

// ---- dffsc_drv.sv ----
// partner: surrounding logic driving cell clock, data, set and clear
`timescale 1ns/10ps
`default_nettype none
module dffsc_drv
    import dffsc_pkg::*;
(
    // system
    input  wire logic           CLK,
    // cell pins
    output var  dffsc_cell_in_t CELL_IN [DFFSC_NUM_CELLS]
);
    // levels change just after an edge so the sampling edge never races them
    task automatic put(input int c, input logic [3:0] v);
        @(posedge CLK);
        CELL_IN[c] <= v;
    endtask : put
    initial begin
        CELL_IN[0] = 4'h3;
        CELL_IN[1] = 4'h3;
    end
endmodule : dffsc_drv
`default_nettype wire

// ---- testbench.sv ----
// testbench: table-driven checks of the dual set/clear storage cells
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dffsc_pkg::*;
    typedef struct { int c; logic [3:0] v; logic q; } dffsc_row_t;
    logic            CLK;
    logic            RESETN;
    dffsc_cell_in_t  cin  [DFFSC_NUM_CELLS];
    dffsc_cell_out_t cout [DFFSC_NUM_CELLS];
    logic            exp_q [DFFSC_NUM_CELLS] = '{1'h0, 1'h0};
    int              num_errors = 0;
    int              num_checks = 0;
    int              cyc = 0;
    // v is {cell_clk, data, async_set_n, async_clear_n}
    dffsc_row_t rows [17] = '{'{0,4'h7,0}, '{0,4'hf,1}, '{0,4'hb,1}, '{0,4'h3,1},
        '{0,4'hb,0}, '{0,4'h7,0}, '{0,4'hf,1}, '{0,4'h6,0}, '{0,4'h7,0}, '{0,4'h1,1},
        '{0,4'h4,0}, '{0,4'he,0}, '{0,4'hf,0}, '{1,4'h7,0}, '{1,4'hf,1}, '{1,4'h9,1},
        '{1,4'h3,1}};
    dffsc_drv drv_u (.CLK(CLK), .CELL_IN(cin));
    dffsc_dual dut_u (.CLK(CLK), .RESETN(RESETN), .CELL_IN(cin), .CELL_OUT(cout));
    initial CLK = 1'h0;
    always #2 CLK = ~CLK;
    task automatic chk(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // a hang counts as a mismatch
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 200) begin
            num_errors++;
            end_of_test();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        RESETN = 1'h0;
        repeat (3) @(posedge CLK);
        RESETN <= 1'h1;
        foreach (rows[i]) begin
            drv_u.put(rows[i].c, rows[i].v);
            exp_q[rows[i].c] = rows[i].q;
            @(posedge CLK);
            #1;
            for (int c = 0; c < DFFSC_NUM_CELLS; c++) begin
                chk("q", exp_q[c], cout[c].q);
                chk("q_n", ~exp_q[c], cout[c].q_n);
            end
        end
        // forcing shows in the same cycle, before any edge stores it
        drv_u.put(0, 4'h1);
        #1;
        chk("q set now", 1'h1, cout[0].q);
        drv_u.put(0, 4'h2);
        #1;
        chk("q clear now", 1'h0, cout[0].q);
        chk("q_n clear now", 1'h1, cout[0].q_n);
        // both low over an edge, then released: a set win would store a one
        drv_u.put(0, 4'h0);
        #1;
        chk("q both low", 1'h0, cout[0].q);
        drv_u.put(0, 4'h3);
        @(posedge CLK);
        #1;
        chk("q after both low", 1'h0, cout[0].q);
        // a rise under clear, then release with the cell clock still high
        drv_u.put(0, 4'he);
        drv_u.put(0, 4'hf);
        @(posedge CLK);
        #1;
        chk("q edge under clear", 1'h0, cout[0].q);
        // second reset in mid-run drops the stored one of cell 1
        @(posedge CLK);
        RESETN <= 1'h0;
        #1;
        chk("q reset", 1'h0, cout[1].q);
        @(posedge CLK);
        RESETN <= 1'h1;
        // cell 0 clock stays high across release: that is no edge
        drv_u.put(1, 4'h7);
        #1;
        chk("q no edge at release", 1'h0, cout[0].q);
        drv_u.put(1, 4'hf);
        #1;
        chk("q before rise", 1'h0, cout[1].q);
        @(posedge CLK);
        #1;
        chk("q first rise", 1'h1, cout[1].q);
        chk("q_n first rise", 1'h0, cout[1].q_n);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
